/* shared/ctl_pkg.sv */
// constants and state types for the four-channel counter/timer loader
// assumes one system clock and a byte-wide processor write port
// ==========================================================
package ctl_pkg;
	localparam int CHANS = 4;
	// control word fields
	localparam int CW_IS_CTRL = 0;
	localparam int CW_RESET = 1;
	localparam int CW_TC_NEXT = 2;
	localparam int CW_TRIG_WAIT = 3;
	localparam int CW_EDGE_POS = 4;
	localparam int CW_PRE_256 = 5;
	localparam int CW_COUNTER = 6;
	localparam int CW_INT_EN = 7;
	// vector layout
	localparam int VEC_BASE_LSB = 3;
	// prescaler terminal values and counter figures
	localparam logic [7:0] PRE_LAST_16 = 8'h0f;
	localparam logic [7:0] PRE_LAST_256 = 8'hff;
	localparam logic [8:0] CNT_FULL = 9'h100;
	localparam logic [8:0] CNT_LAST = 9'h001;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] tc;
		logic [8:0] cnt;
		logic tc_ok;
		logic run;
		logic armed;
		logic exp_tc;
		logic [7:0] pre;
		logic [2:0] sync;
		logic lvl;
		logic pend;
	} ctl_chan_t;

	typedef struct packed {
		ctl_chan_t [CHANS-1:0] ch;
		logic [4:0] vbase;
		logic irq;
		logic [7:0] vec;
		logic vec_vld;
		logic [CHANS-1:0] zc;
	} ctl_state_t;
endpackage

/* src/ctl_loader.sv */
// four-channel down counter/timer with write decode and vectored interrupts
// assumes writes are one-cycle strobes on REF_CLK_I; trigger pins are asynchronous
`timescale 1ns/1ps
module ctl_loader import ctl_pkg::*; (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	// processor write port
	input wire logic WR_STB_I,
	input wire logic [1:0] WR_CHAN_I,
	input wire logic [7:0] WR_DATA_I,
	// external count or trigger pins
	input wire logic [CHANS-1:0] EXTERNAL_COUNT_TRIGGER_I,
	// interrupt acknowledge
	input wire logic INT_ACK_I,
	// outputs
	output logic INT_REQ_O,
	output logic [7:0] VEC_O,
	output logic VEC_VALID_O,
	output logic [CHANS-1:0] ZERO_COUNT_O
);
	// ==========================================================
	// helpers
	function automatic logic [8:0] tc_count(input logic [7:0] tc);
		tc_count = (tc == 8'h00) ? CNT_FULL : {1'b0, tc};
	endfunction

	ctl_state_t r;
	ctl_state_t next_r;
	logic [CHANS-1:0] tick;
	logic [CHANS-1:0] trig;

	// ==========================================================
	// next state
	always_comb begin
		ctl_chan_t c;
		logic started;
		logic found;
		logic [1:0] code;
		c = '0;
		started = 1'b0;
		found = 1'b0;
		code = 2'b00;
		next_r = r;
		next_r.vec_vld = 1'b0;
		next_r.zc = '0;
		tick = '0;
		trig = '0;
		// acknowledge: lowest pending channel number wins
		for (int i = CHANS - 1; i >= 0; i--) begin
			if (r.ch[i].pend && r.ch[i].ctrl[CW_INT_EN]) begin
				found = 1'b1;
				code = i[1:0];
			end
		end
		if (INT_ACK_I && found) begin
			next_r.vec = {r.vbase, code, 1'b0};
			next_r.vec_vld = 1'b1;
			next_r.ch[code].pend = 1'b0;
		end
		for (int i = 0; i < CHANS; i++) begin
			c = next_r.ch[i];
			started = 1'b0;
			// three-stage pin sampler; stage 0 only feeds stage 1
			c.sync = {c.sync[1:0], EXTERNAL_COUNT_TRIGGER_I[i]};
			if (r.ch[i].sync[1] == r.ch[i].sync[2] && r.ch[i].sync[2] != r.ch[i].lvl) begin
				c.lvl = r.ch[i].sync[2];
				trig[i] = (r.ch[i].sync[2] == r.ch[i].ctrl[CW_EDGE_POS]);
			end
			// processor writes
			if (WR_STB_I && WR_CHAN_I == i[1:0]) begin
				if (r.ch[i].exp_tc) begin
					c.tc = WR_DATA_I;
					c.tc_ok = 1'b1;
					c.exp_tc = 1'b0;
					if (!r.ch[i].run && !r.ch[i].armed) begin
						// first constant starts the channel; later ones wait for zero
						c.cnt = tc_count(WR_DATA_I);
						c.pre = '0;
						started = 1'b1;
						if (!r.ch[i].ctrl[CW_COUNTER] && r.ch[i].ctrl[CW_TRIG_WAIT])
							c.armed = 1'b1;
						else
							c.run = 1'b1;
					end
				end else if (WR_DATA_I[CW_IS_CTRL]) begin
					// reset bit is a pulse and is never stored
					c.ctrl = {WR_DATA_I[7:2], 1'b0, 1'b1};
					c.exp_tc = WR_DATA_I[CW_TC_NEXT];
					if (!WR_DATA_I[CW_INT_EN])
						c.pend = 1'b0;
					if (WR_DATA_I[CW_RESET]) begin
						c.run = 1'b0;
						c.armed = 1'b0;
						c.pre = '0;
					end
				end else begin
					// bits 2:1 are dropped; they are rebuilt at acknowledge
					next_r.vbase = WR_DATA_I[7:VEC_BASE_LSB];
				end
			end
			// a trigger edge releases an armed timer
			if (c.armed && trig[i] && !started) begin
				c.armed = 1'b0;
				c.run = 1'b1;
			end
			// counting
			if (c.run && !started) begin
				if (c.ctrl[CW_COUNTER]) begin
					tick[i] = trig[i];
				end else begin
					tick[i] = (c.pre == (c.ctrl[CW_PRE_256] ? PRE_LAST_256 : PRE_LAST_16));
					c.pre = tick[i] ? 8'h00 : c.pre + 8'h01;
				end
				if (tick[i]) begin
					if (c.cnt == CNT_LAST) begin
						c.cnt = tc_count(c.tc);
						next_r.zc[i] = 1'b1;
						if (c.ctrl[CW_INT_EN])
							c.pend = 1'b1;
					end else begin
						c.cnt = c.cnt - 9'h001;
					end
				end
			end
			next_r.ch[i] = c;
		end
		next_r.irq = 1'b0;
		for (int i = 0; i < CHANS; i++)
			next_r.irq = next_r.irq | (next_r.ch[i].pend & next_r.ch[i].ctrl[CW_INT_EN]);
	end

	// ==========================================================
	// state register, synchronous reset
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I)
			r <= '0;
		else
			r <= next_r;
	end

	assign INT_REQ_O = r.irq;
	assign VEC_O = r.vec;
	assign VEC_VALID_O = r.vec_vld;
	assign ZERO_COUNT_O = r.zc;

	// ==========================================================
	// checks on channel 0, counter mode of channel 3 and the shared vector
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);

	// plain flag so that properties can exclude a write without naming a sequence
	logic wr_ch0;
	assign wr_ch0 = WR_STB_I && WR_CHAN_I == 2'h0;

	sequence s_ctrl_tc0;
		wr_ch0 && WR_DATA_I[CW_IS_CTRL] && WR_DATA_I[CW_TC_NEXT] && !r.ch[0].exp_tc;
	endsequence
	sequence s_wr0;
		wr_ch0;
	endsequence

	property p_no_run_without_tc;
		r.ch[0].run |-> r.ch[0].tc_ok;
	endproperty
	a_no_run_without_tc: assert property (p_no_run_without_tc) else $error("channel runs without constant");

	property p_tc_next_write;
		s_ctrl_tc0 ##1 !wr_ch0 ##1 s_wr0 |=> r.ch[0].tc == $past(WR_DATA_I) && r.ch[0].tc_ok;
	endproperty
	a_tc_next_write: assert property (p_tc_next_write) else $error("constant not taken from next write");

	property p_zero_is_256;
		s_wr0 and (r.ch[0].exp_tc && !r.ch[0].run && !r.ch[0].armed && WR_DATA_I == 8'h00)
			|=> r.ch[0].cnt == CNT_FULL;
	endproperty
	a_zero_is_256: assert property (p_zero_is_256) else $error("zero constant not 256");

	property p_tc_waits;
		s_wr0 and (r.ch[0].exp_tc && r.ch[0].run && r.ch[0].cnt > CNT_LAST)
			|=> r.ch[0].cnt == $past(r.ch[0].cnt) || r.ch[0].cnt == $past(r.ch[0].cnt) - 9'h001;
	endproperty
	a_tc_waits: assert property (p_tc_waits) else $error("running counter reloaded early");

	property p_vec_ch0;
		INT_ACK_I && r.ch[0].pend && r.ch[0].ctrl[7]
			|=> VEC_VALID_O && VEC_O == {r.vbase, 3'h0} ##1 !VEC_VALID_O;
	endproperty
	a_vec_ch0: assert property (p_vec_ch0) else $error("vector for channel 0 wrong");

	property p_vec_base;
		WR_STB_I && !r.ch[WR_CHAN_I].exp_tc && !WR_DATA_I[0] |=> r.vbase == $past(WR_DATA_I[7:3]);
	endproperty
	a_vec_base: assert property (p_vec_base) else $error("vector base not stored");

	property p_zero_irq;
		tick[0] && r.ch[0].cnt == CNT_LAST && r.ch[0].ctrl[CW_INT_EN] && !wr_ch0
			|=> r.ch[0].pend && INT_REQ_O;
	endproperty
	a_zero_irq: assert property (p_zero_irq) else $error("zero count raised no request");

	property p_counter_waits_edge;
		r.ch[3].run && r.ch[3].ctrl[CW_COUNTER] && !trig[3] && !(WR_STB_I && WR_CHAN_I == 2'h3)
			|=> $stable(r.ch[3].cnt);
	endproperty
	a_counter_waits_edge: assert property (p_counter_waits_edge) else $error("counter moved without edge");

	property p_prescale_16;
		r.ch[0].run && !r.ch[0].ctrl[6] && !r.ch[0].ctrl[5] && r.ch[0].pre == 8'h0f
			&& r.ch[0].cnt > CNT_LAST && !wr_ch0 |=> r.ch[0].cnt == $past(r.ch[0].cnt) - 9'h001;
	endproperty
	a_prescale_16: assert property (p_prescale_16) else $error("prescaler by 16 wrong");

	property p_soft_reset;
		s_wr0 and (!r.ch[0].exp_tc && WR_DATA_I[CW_IS_CTRL] && WR_DATA_I[CW_RESET])
			|=> !r.ch[0].run && !r.ch[0].ctrl[1] && r.ch[0].ctrl[7:2] == $past(WR_DATA_I[7:2]);
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("software reset wrong");

	property p_reload;
		tick[0] && r.ch[0].cnt == CNT_LAST && !wr_ch0
			|=> r.ch[0].cnt == tc_count(r.ch[0].tc) && ZERO_COUNT_O[0];
	endproperty
	a_reload: assert property (p_reload) else $error("no reload at zero");
endmodule

/* test/ctl_cpu_model.sv */
// processor stand-in: port writes and interrupt acknowledges
// assumes the bench calls its tasks; lines change on falling edges
`timescale 1ns/1ps
module ctl_cpu_model import ctl_pkg::*; (
	// clock
	input wire logic clk_i,
	// write port and acknowledge
	output logic wr_stb_o,
	output logic [1:0] wr_chan_o,
	output logic [7:0] wr_data_o,
	output logic int_ack_o,
	// vector return
	input wire logic [7:0] vec_i,
	input wire logic vec_valid_i
);
	// ==========================================
	// bus tasks
	initial begin
		wr_stb_o = 1'b0;
		wr_chan_o = 2'h0;
		wr_data_o = 8'h00;
		int_ack_o = 1'b0;
	end
	// one write held across one rising edge; released lines flip, not hold
	task automatic wr(input logic [1:0] c, input logic [7:0] d);
		@(negedge clk_i);
		wr_stb_o = 1'b1;
		wr_chan_o = c;
		wr_data_o = d;
		@(negedge clk_i);
		wr_stb_o = 1'b0;
		wr_chan_o = ~c;
		wr_data_o = ~d;
	endtask
	// control word always followed by its constant on the same channel
	task automatic ld(input logic [1:0] c, input logic [7:0] cw, input logic [7:0] tc);
		wr(c, cw);
		wr(c, tc);
	endtask
	// vector base goes to channel 0 with bit 0 clear
	task automatic setvec(input logic [7:0] d);
		wr(2'h0, {d[7:1], 1'b0});
	endtask
	// one-cycle acknowledge; the answer is taken at the next falling edge
	task automatic ack(output logic [7:0] v, output logic ok);
		@(negedge clk_i);
		int_ack_o = 1'b1;
		@(negedge clk_i);
		int_ack_o = 1'b0;
		v = vec_i;
		ok = vec_valid_i;
	endtask
endmodule

/* test/ctl_loader_tb.sv */
// self-checking bench for the counter/timer loader
// assumes the processor model drives the write port
`timescale 1ns/1ps
module ctl_loader_tb import ctl_pkg::*; ();
	logic clk;
	logic rst_n;
	logic [CHANS-1:0] trig;
	logic wr_stb;
	logic [1:0] wr_chan;
	logic [7:0] wr_data;
	logic int_ack;
	logic int_req;
	logic [7:0] vec;
	logic vec_valid;
	logic [CHANS-1:0] zc;
	int n_mismatch = 0;
	int check_count = 0;
	int nz3 = 0;
	logic [15:0] n;
	logic [7:0] v;
	logic ok;
	// ==========================================
	// clock, instances
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	ctl_loader uut (.REF_CLK_I(clk), .RST_N_I(rst_n), .WR_STB_I(wr_stb), .WR_CHAN_I(wr_chan),
		.WR_DATA_I(wr_data), .EXTERNAL_COUNT_TRIGGER_I(trig), .INT_ACK_I(int_ack),
		.INT_REQ_O(int_req), .VEC_O(vec), .VEC_VALID_O(vec_valid), .ZERO_COUNT_O(zc));
	ctl_cpu_model cpu (.clk_i(clk), .wr_stb_o(wr_stb), .wr_chan_o(wr_chan), .wr_data_o(wr_data),
		.int_ack_o(int_ack), .vec_i(vec), .vec_valid_i(vec_valid));
	// channel 3 zero pulses, counted where outputs are settled
	always @(negedge clk) begin
		if (zc[3] === 1'b1) nz3++;
	end
	// ==========================================
	// helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %0h want %0h", $time, seen, exp);
		end
	endtask
	// cycles to the next zero pulse, capped so a dead channel cannot hang
	task automatic gap(input int c, input logic [15:0] lim);
		n = 16'h0000;
		do begin
			@(negedge clk);
			n++;
		end while (zc[c] !== 1'b1 && n < lim);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_timer();
		cpu.wr(2'h0, 8'h81);
		gap(0, 16'h1400);
		check(n, 16'h1400);
		cpu.ld(2'h0, 8'h05, 8'h02);
		gap(0, 16'h1400);
		gap(0, 16'h1400);
		check(n, 16'h0020);
		cpu.ld(2'h0, 8'h05, 8'h04);
		gap(0, 16'h1400);
		check(n, 16'h001c);
		gap(0, 16'h1400);
		check(n, 16'h0040);
		cpu.ld(2'h0, 8'h25, 8'h01);
		gap(0, 16'h1400);
		gap(0, 16'h1400);
		check(n, 16'h0100);
		// stop first, so the zero constant starts a fresh count
		cpu.ld(2'h0, 8'h07, 8'h00);
		gap(0, 16'h1400);
		check(n, 16'h1000);
		gap(0, 16'h1400);
		check(n, 16'h1000);
		cpu.wr(2'h0, 8'h03);
		$display("timer test done");
	endtask
	// three channels pending at once: priority, code, base bits
	task automatic t_vec();
		cpu.setvec(8'hae);
		cpu.ld(2'h0, 8'ha5, 8'h01);
		cpu.ld(2'h1, 8'ha5, 8'h01);
		cpu.ld(2'h2, 8'h85, 8'h01);
		repeat (300) @(negedge clk);
		check(int_req, 16'h0001);
		cpu.ack(v, ok);
		check({ok, v}, 16'h01a8);
		cpu.ack(v, ok);
		check({ok, v}, 16'h01aa);
		cpu.ack(v, ok);
		check({ok, v}, 16'h01ac);
		cpu.wr(2'h0, 8'h03);
		cpu.wr(2'h1, 8'h03);
		cpu.wr(2'h2, 8'h03);
		repeat (2) @(negedge clk);
		check(int_req, 16'h0000);
		cpu.ack(v, ok);
		check({ok, v}, 16'h00ac);
		gap(2, 16'h0258);
		check(n, 16'h0258);
		$display("vector test done");
	endtask
	// counter mode on rising pin edges, constant of three
	task automatic t_cnt();
		cpu.ld(2'h3, 8'h55, 8'h03);
		for (int i = 0; i < 3; i++) begin
			check(nz3, 16'h0000);
			trig[3] = 1'b1;
			repeat (6) @(negedge clk);
			trig[3] = 1'b0;
			repeat (6) @(negedge clk);
		end
		check(nz3, 16'h0001);
		$display("counter test done");
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		rst_n = 1'b0;
		trig = 4'h0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		t_timer();
		t_vec();
		t_cnt();
		complete_run();
	end
	// about twice the expected run length
	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		complete_run();
	end
endmodule
